// *** msc_defines.svh ***
// Constants for the mode and supply control register bank and its serial link
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH

// Frame layout, first bit on the wire is bit 0
`define MSC_FRAME_BITS 5'h10
`define MSC_HDR_BITS 5'h08
`define MSC_ACCESS_BIT 7
`define MSC_DATA_HI 15
`define MSC_DATA_LO 8

// Register addresses
`define MSC_REG_MODE_SUPPLY 7'h01
`define MSC_REG_SUPPLY_CFG 7'h02
`define MSC_REG_SUPPLY_STAT 7'h40

// Mode and supply control fields
`define MSC_MODE_HI 7
`define MSC_MODE_LO 6
`define MSC_THIRD_BIT 5
`define MSC_SECOND_HI 4
`define MSC_SECOND_LO 3
`define MSC_OV_RST_BIT 2
`define MSC_RT_HI 1
`define MSC_RT_LO 0
`define MSC_MODE_NORMAL 2'h0
`define MSC_MODE_SLEEP 2'h1
`define MSC_MODE_STOP 2'h2
`define MSC_MODE_SOFT_RESET 2'h3
`define MSC_SECOND_OFF 2'h0

// Reset, soft reset and restart values
`define MSC_MODE_SUPPLY_RESET 8'h00
`define MSC_MODE_SUPPLY_RESTART_KEEP 8'h23
`define MSC_CFG_RESET 8'h00
`define MSC_CFG_SOFT_KEEP 8'h88
`define MSC_CFG_RESTART_KEEP 8'hd9
`define MSC_CFG_WRITE_MASK 8'hfb
`define MSC_CFG_SOFT_RO_BIT 6
`define MSC_STAT_OV_BIT 1

// Timing
`define MSC_CLK_NS 50
`define MSC_SCLK_HALF_NS 200
`define MSC_SCLK_HALF_CYC ((`MSC_SCLK_HALF_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)
`define MSC_RST_PULSE_NS 2000
`define MSC_RST_PULSE_CYC ((`MSC_RST_PULSE_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)

`endif

// *** msc_link_properties.sv ***
// Wire-level properties of the serial link between the two ends
`timescale 1ns/1ps
`default_nettype none
module msc_link_properties (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic [4:0] rise_cnt_q;
    logic sclk_q;

    // Rising clock edges seen in the current frame
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rise_cnt_q <= 5'h00;
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
            if (cs_n) begin
                rise_cnt_q <= 5'h00;
            end else if (sclk && !sclk_q) begin
                rise_cnt_q <= rise_cnt_q + 5'h01;
            end
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_high_phase;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence s_low_phase;
        !sclk [*4];
    endsequence

    a_idle_clock_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    a_high_phase_len: assert property ($rose(sclk) |-> s_high_phase)
        else $error("serial clock high phase not four cycles");
    a_low_phase_len: assert property ($fell(sclk) && !cs_n |-> s_low_phase)
        else $error("serial clock low phase too short");
    a_sixteen_rises: assert property ($rose(cs_n) |-> rise_cnt_q == 5'h10)
        else $error("frame did not carry sixteen bits");
    a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*2])
        else $error("frames closer than two cycles");
    a_frame_bounded: assert property ($fell(cs_n) |-> ##[125:135] $rose(cs_n))
        else $error("frame length out of range");
    a_header_reply_zero: assert property ($rose(sclk) && rise_cnt_q < 5'h08 |-> !miso)
        else $error("reply header bit not zero");
    a_reply_steady: assert property (sclk && $past(sclk) |-> $stable(miso))
        else $error("reply bit moved while clock high");
    a_command_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("command bit moved while clock high");
    a_bank_released: assert property (cs_n && $past(cs_n) |-> !miso && !miso_oe)
        else $error("bank drives reply line while deselected");
    a_bank_drives: assert property (!cs_n && !$past(cs_n) |-> miso_oe)
        else $error("bank not driving reply line in frame");
endmodule
`default_nettype wire

// *** msc_mode_supply_regs.sv ***
// Register bank end: mode and supply control reached over the serial link
`timescale 1ns/1ps
`default_nettype none
`include "msc_defines.svh"
module msc_mode_supply_regs (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic restart_entry_i,
    input wire logic overtemp_i,
    input wire logic main_overvoltage_i,
    output logic [1:0] device_mode_o,
    output logic third_regulator_enable_o,
    output logic [1:0] second_regulator_mode_o,
    output logic main_overvoltage_restart_enable_o,
    output logic [1:0] main_reset_threshold_o,
    output logic main_overvoltage_flag_o,
    output logic overvoltage_restart_req_o,
    output logic soft_reset_o,
    output logic soft_reset_output_pulse_cfg_o,
    output logic reset_output_pin_low_o,
    msc_spi_if.device spi
);
    localparam logic [5:0] RST_PULSE = 6'(`MSC_RST_PULSE_CYC);

    msc_pkg::msc_dev_state_type s;
    msc_pkg::msc_dev_state_type n;
    logic hdr;
    logic done;
    logic [15:0] frame;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic is_write;
    logic [7:0] reply;
    logic wr_frame;
    logic soft_req;

    // Device mode field of a control byte
    function automatic logic [1:0] mode_field(input logic [7:0] b);
        return b[`MSC_MODE_HI:`MSC_MODE_LO];
    endfunction

    // Stop to sleep is not a legal request
    function automatic logic stop_to_sleep(input logic [7:0] old_b, input logic [7:0] new_b);
        return mode_field(old_b) == `MSC_MODE_STOP && mode_field(new_b) == `MSC_MODE_SLEEP;
    endfunction

    // Read view of one register
    function automatic logic [7:0] read_reg(
        input logic [6:0] a,
        input msc_pkg::msc_dev_state_type st
    );
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `MSC_REG_MODE_SUPPLY: v = st.mode_supply;
            `MSC_REG_SUPPLY_CFG: v = st.supply_cfg & `MSC_CFG_WRITE_MASK;
            `MSC_REG_SUPPLY_STAT: v[`MSC_STAT_OV_BIT] = st.ov_flag;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    msc_spi_shifter u_shifter (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .sclk_i(spi.sclk),
        .cs_n_i(spi.cs_n),
        .mosi_i(spi.mosi),
        .tx_i(reply),
        .miso_o(spi.miso),
        .miso_oe_o(spi.miso_oe),
        .hdr_o(hdr),
        .done_o(done),
        .frame_o(frame)
    );

    assign addr = frame[6:0];
    assign wdata = frame[`MSC_DATA_HI:`MSC_DATA_LO];
    assign is_write = frame[`MSC_ACCESS_BIT];

    assign wr_frame = done && is_write;
    // mode value three is soft reset
    assign soft_req = wr_frame && addr == `MSC_REG_MODE_SUPPLY &&
        mode_field(wdata) == `MSC_MODE_SOFT_RESET;

    assign reply = read_reg(addr, s);

    always_comb begin
        n = s;
        n.restart_req = 1'b0;
        n.soft_pulse = 1'b0;

        if (s.rst_cnt != 6'h00) begin
            n.rst_cnt = s.rst_cnt - 6'h01;
            if (s.rst_cnt == 6'h01) begin
                n.rst_low = 1'b0;
            end
        end

        if (wr_frame) begin
            case (addr)
                `MSC_REG_MODE_SUPPLY: begin
                    if (soft_req) begin
                        n.mode_supply = `MSC_MODE_SUPPLY_RESET;
                        n.supply_cfg = s.supply_cfg & `MSC_CFG_SOFT_KEEP;
                        n.ov_flag = 1'b0;
                        n.soft_pulse = 1'b1;
                        if (!s.supply_cfg[`MSC_CFG_SOFT_RO_BIT]) begin
                            n.rst_low = 1'b1;
                            n.rst_cnt = RST_PULSE;
                        end
                    end else begin
                        n.mode_supply = wdata;
                        if (stop_to_sleep(s.mode_supply, wdata)) begin
                            n.mode_supply[`MSC_MODE_HI:`MSC_MODE_LO] = `MSC_MODE_STOP;
                        end
                    end
                end
                `MSC_REG_SUPPLY_CFG: begin
                    n.supply_cfg = wdata & `MSC_CFG_WRITE_MASK;
                end
                `MSC_REG_SUPPLY_STAT: begin
                    if (wdata[`MSC_STAT_OV_BIT]) begin
                        n.ov_flag = 1'b0;
                    end
                end
                default: begin
                    n.ov_flag = n.ov_flag;
                end
            endcase
        end

        if (restart_entry_i) begin
            n.mode_supply = n.mode_supply & `MSC_MODE_SUPPLY_RESTART_KEEP;
            n.supply_cfg = n.supply_cfg & `MSC_CFG_RESTART_KEEP;
        end

        if (overtemp_i) begin
            n.mode_supply[`MSC_SECOND_HI:`MSC_SECOND_LO] = `MSC_SECOND_OFF;
        end

        if (main_overvoltage_i) begin
            n.ov_flag = 1'b1;
            n.restart_req = s.mode_supply[`MSC_OV_RST_BIT];
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign device_mode_o = mode_field(s.mode_supply);
    assign third_regulator_enable_o = s.mode_supply[`MSC_THIRD_BIT];
    assign second_regulator_mode_o = s.mode_supply[`MSC_SECOND_HI:`MSC_SECOND_LO];
    assign main_overvoltage_restart_enable_o = s.mode_supply[`MSC_OV_RST_BIT];
    assign main_reset_threshold_o = s.mode_supply[`MSC_RT_HI:`MSC_RT_LO];
    assign main_overvoltage_flag_o = s.ov_flag;
    assign overvoltage_restart_req_o = s.restart_req;
    assign soft_reset_o = s.soft_pulse;
    assign soft_reset_output_pulse_cfg_o = s.supply_cfg[`MSC_CFG_SOFT_RO_BIT];
    assign reset_output_pin_low_o = s.rst_low;
endmodule
`default_nettype wire

// *** msc_pkg.sv ***
// Types shared by both ends of the mode and supply control link
`default_nettype none
package msc_pkg;

    typedef enum logic [1:0] {MSC_IDLE, MSC_LOW, MSC_HIGH, MSC_TRAIL} msc_ctrl_fsm_type;

    typedef struct packed {
        logic sclk;
        logic [4:0] cnt;
        logic [15:0] rx;
        logic [7:0] tx;
        logic miso;
        logic miso_oe;
        logic hdr;
        logic done;
    } msc_shift_state_type;

    typedef struct packed {
        logic [7:0] mode_supply;
        logic [7:0] supply_cfg;
        logic ov_flag;
        logic restart_req;
        logic soft_pulse;
        logic rst_low;
        logic [5:0] rst_cnt;
    } msc_dev_state_type;

    typedef struct packed {
        msc_ctrl_fsm_type st;
        logic [3:0] tmr;
        logic [3:0] bit_idx;
        logic [15:0] cmd;
        logic [15:0] rsp;
        logic [15:0] rdata;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic done;
    } msc_ctrl_state_type;

endpackage
`default_nettype wire

// *** msc_spi_controller.sv ***
// Controller end: software command port driving the serial link
`timescale 1ns/1ps
`default_nettype none
`include "msc_defines.svh"
module msc_spi_controller (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wstb_i,
    input wire logic reg_rstb_i,
    output logic [15:0] reg_rdata_o,
    msc_spi_if.controller spi
);
    localparam logic [1:0] CTRL_CMD = 2'h0;
    localparam logic [1:0] CTRL_STAT = 2'h1;
    localparam logic [1:0] CTRL_RSP = 2'h2;
    localparam logic [3:0] HALF_LAST = 4'(`MSC_SCLK_HALF_CYC - 1);

    msc_pkg::msc_ctrl_state_type s;
    msc_pkg::msc_ctrl_state_type n;
    logic half_done;

    always_comb begin
        n = s;
        half_done = (s.tmr == HALF_LAST);
        n.rdata = 16'h0000;
        if (reg_rstb_i) begin
            case (reg_addr_i)
                CTRL_CMD: n.rdata = s.cmd;
                CTRL_STAT: n.rdata = {14'h0000, s.done, s.st != msc_pkg::MSC_IDLE};
                CTRL_RSP: n.rdata = s.rsp;
                default: n.rdata = 16'h0000;
            endcase
        end
        if (reg_wstb_i && reg_addr_i == CTRL_STAT && reg_wdata_i[1]) begin
            n.done = 1'b0;
        end
        n.tmr = half_done ? 4'h0 : s.tmr + 4'h1;
        case (s.st)
            msc_pkg::MSC_IDLE: begin
                n.tmr = 4'h0;
                // address, access bit, then data byte
                if (reg_wstb_i && reg_addr_i == CTRL_CMD) begin
                    n.cmd = reg_wdata_i;
                    n.cs_n = 1'b0;
                    n.mosi = reg_wdata_i[0];
                    n.bit_idx = 4'h0;
                    n.st = msc_pkg::MSC_LOW;
                end
            end
            msc_pkg::MSC_LOW: begin
                if (half_done) begin
                    n.sclk = 1'b1;
                    n.rsp[s.bit_idx] = spi.miso;
                    n.st = msc_pkg::MSC_HIGH;
                end
            end
            msc_pkg::MSC_HIGH: begin
                if (half_done) begin
                    n.sclk = 1'b0;
                    if (s.bit_idx == 4'hf) begin
                        n.st = msc_pkg::MSC_TRAIL;
                    end else begin
                        n.bit_idx = s.bit_idx + 4'h1;
                        n.mosi = s.cmd[s.bit_idx + 4'h1];
                        n.st = msc_pkg::MSC_LOW;
                    end
                end
            end
            msc_pkg::MSC_TRAIL: begin
                if (half_done) begin
                    n.cs_n = 1'b1;
                    n.done = 1'b1;
                    n.st = msc_pkg::MSC_IDLE;
                end
            end
            default: n.st = msc_pkg::MSC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
            s.cs_n <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata_o = s.rdata;
    assign spi.sclk = s.sclk;
    assign spi.cs_n = s.cs_n;
    assign spi.mosi = s.mosi;
endmodule
`default_nettype wire

// *** msc_spi_if.sv ***
// Serial link between the controller and the register bank
`timescale 1ns/1ps
`default_nettype none
interface msc_spi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;

    modport device (input sclk, input cs_n, input mosi, output miso, output miso_oe);
    modport controller (output sclk, output cs_n, output mosi, input miso, input miso_oe);
endinterface
`default_nettype wire

// *** msc_spi_shifter.sv ***
// Frame shifter of the register bank end
`timescale 1ns/1ps
`default_nettype none
`include "msc_defines.svh"
module msc_spi_shifter (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    input wire logic [7:0] tx_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic hdr_o,
    output logic done_o,
    output logic [15:0] frame_o
);
    msc_pkg::msc_shift_state_type s;
    msc_pkg::msc_shift_state_type n;

    always_comb begin
        n = s;
        n.hdr = 1'b0;
        n.done = 1'b0;
        n.sclk = sclk_i;
        n.miso_oe = !cs_n_i;
        if (cs_n_i) begin
            n.cnt = 5'h00;
            n.miso = 1'b0;
        end else begin
            // Reply byte latched once the address is in
            if (s.hdr) begin
                n.tx = tx_i;
            end
            if (sclk_i && !s.sclk && s.cnt < `MSC_FRAME_BITS) begin
                n.rx[s.cnt[3:0]] = mosi_i;
                n.cnt = s.cnt + 5'h01;
                n.hdr = (s.cnt == `MSC_HDR_BITS - 5'h01);
                n.done = (s.cnt == `MSC_FRAME_BITS - 5'h01);
            end
            // data bits on frame bits 8 to 15
            if (!sclk_i && s.sclk && s.cnt >= `MSC_HDR_BITS && s.cnt < `MSC_FRAME_BITS) begin
                n.miso = s.tx[s.cnt[2:0]];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign miso_o = s.miso;
    assign miso_oe_o = s.miso_oe;
    assign hdr_o = s.hdr;
    assign done_o = s.done;
    assign frame_o = s.rx;
endmodule
`default_nettype wire

// *** test_mode_supply_control_regs.sv ***
// Self-checking bench joining controller and register bank over the link
`timescale 1ns/1ps
`default_nettype none
module test_mode_supply_control_regs;
    logic core_clk, resetn, wstb, rstb, restart, otemp, ovolt;
    logic [1:0] addr, mode, second, thresh;
    logic [15:0] wdata, rdata;
    logic third, ov_en, ov_flag, ov_req, soft_rst, pin_cfg, pin_low;
    int error_cnt = 0;
    int check_count = 0;
    int soft_seen = 0;
    int low_cycles = 0;
    int req_seen = 0;

    msc_spi_if msc_spi_if_i ();
    msc_spi_controller msc_spi_controller_i (.core_clk_i(core_clk), .resetn_i(resetn),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wstb_i(wstb), .reg_rstb_i(rstb),
        .reg_rdata_o(rdata), .spi(msc_spi_if_i.controller));
    msc_mode_supply_regs msc_mode_supply_regs_i (.core_clk_i(core_clk), .resetn_i(resetn),
        .restart_entry_i(restart), .overtemp_i(otemp), .main_overvoltage_i(ovolt),
        .device_mode_o(mode), .third_regulator_enable_o(third),
        .second_regulator_mode_o(second), .main_overvoltage_restart_enable_o(ov_en),
        .main_reset_threshold_o(thresh), .main_overvoltage_flag_o(ov_flag),
        .overvoltage_restart_req_o(ov_req), .soft_reset_o(soft_rst),
        .soft_reset_output_pulse_cfg_o(pin_cfg), .reset_output_pin_low_o(pin_low),
        .spi(msc_spi_if_i.device));
    msc_link_properties msc_link_properties_i (.core_clk_i(core_clk), .resetn_i(resetn),
        .sclk(msc_spi_if_i.sclk), .cs_n(msc_spi_if_i.cs_n), .mosi(msc_spi_if_i.mosi),
        .miso(msc_spi_if_i.miso), .miso_oe(msc_spi_if_i.miso_oe));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Pulse counters for the one-cycle outputs and a level counter for the reset pin low output
    always @(posedge core_clk) begin
        if (soft_rst === 1'b1) soft_seen++;
        if (pin_low === 1'b1) low_cycles++;
        if (ov_req === 1'b1) req_seen++;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge core_clk);
        wstb <= 1'b0;
    endtask

    task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge core_clk);
        rstb <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic xfer(input logic [6:0] a, input logic wr, input logic [7:0] d,
                        output logic [7:0] old);
        logic [15:0] s;
        int n;
        bus_wr(2'h0, {d, wr, a});
        n = 0;
        do begin
            bus_rd(2'h1, s);
            n++;
        end while (s[0] !== 1'b0 && n < 200);
        chk("status", s & 16'h0003, 16'h0002);
        bus_rd(2'h2, s);
        chk("reply low", s & 16'h00ff, 16'h0000);
        old = s[15:8];
        bus_wr(2'h1, 16'h0002);
    endtask

    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] o;
        xfer(a, 1'b1, d, o);
    endtask

    task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] e);
        logic [7:0] o;
        xfer(a, 1'b0, 8'h00, o);
        chk(what, {8'h00, o}, {8'h00, e});
    endtask

    task automatic out_chk(input logic [7:0] e);
        chk("outputs", {8'h00, mode, third, second, ov_en, thresh}, {8'h00, e});
    endtask

    task automatic ev(input logic [2:0] e);
        @(posedge core_clk);
        {restart, otemp, ovolt} <= e;
        @(posedge core_clk);
        {restart, otemp, ovolt} <= 3'h0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset();
        out_chk(8'h00);
        rd_chk("ctrl reset", 7'h01, 8'h00);
        rd_chk("cfg reset", 7'h02, 8'h00);
        $display("end reset test");
    endtask

    task automatic t_rw();
        logic [7:0] o;
        wr_reg(7'h01, 8'h2f);
        out_chk(8'h2f);
        rd_chk("read once", 7'h01, 8'h2f);
        rd_chk("read twice", 7'h01, 8'h2f);
        xfer(7'h01, 1'b1, 8'h4a, o);
        chk("write reply", {8'h00, o}, 16'h002f);
        out_chk(8'h4a);
        $display("end read write test");
    endtask

    task automatic t_modes();
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            d = {(i == 3) ? 2'h0 : 2'(i), 1'b0, 2'(i), 1'b0, 2'(i)};
            wr_reg(7'h01, d);
            out_chk(d);
        end
        wr_reg(7'h01, 8'h80);
        wr_reg(7'h01, 8'h41);
        out_chk(8'h81);
        $display("end mode test");
    endtask

    task automatic t_restart();
        wr_reg(7'h01, 8'hbf);
        ev(3'h4);
        out_chk(8'h23);
        rd_chk("restart value", 7'h01, 8'h23);
        $display("end restart test");
    endtask

    task automatic t_heat();
        wr_reg(7'h01, 8'h3b);
        ev(3'h2);
        out_chk(8'h23);
        chk("third on", {15'h0000, third}, 16'h0001);
        $display("end overtemp test");
    endtask

    task automatic t_ovolt();
        logic [7:0] o;
        int r0;
        wr_reg(7'h01, 8'h04);
        r0 = req_seen;
        ev(3'h1);
        chk("ov flag", {15'h0000, ov_flag}, 16'h0001);
        chk("ov request", 16'(req_seen - r0), 16'h0001);
        wr_reg(7'h01, 8'h00);
        ev(3'h1);
        chk("no request", 16'(req_seen - r0), 16'h0001);
        xfer(7'h40, 1'b1, 8'h02, o);
        chk("flag reply", {8'h00, o}, 16'h0002);
        chk("flag cleared", {15'h0000, ov_flag}, 16'h0000);
        $display("end overvoltage test");
    endtask

    task automatic t_reserved();
        logic [15:0] s;
        wr_reg(7'h02, 8'hff);
        rd_chk("reserved zero", 7'h02, 8'hfb);
        chk("pin cfg", {15'h0000, pin_cfg}, 16'h0001);
        wr_reg(7'h05, 8'hff);
        rd_chk("unmapped", 7'h05, 8'h00);
        bus_rd(2'h3, s);
        chk("port unmapped", s, 16'h0000);
        $display("end reserved test");
    endtask

    task automatic t_soft();
        int s0;
        int l0;
        s0 = soft_seen;
        l0 = low_cycles;
        wr_reg(7'h01, 8'hc0);
        repeat (60) @(posedge core_clk);
        chk("soft pulse", 16'(soft_seen - s0), 16'h0001);
        chk("no pin pulse", 16'(low_cycles - l0), 16'h0000);
        out_chk(8'h00);
        rd_chk("soft keep", 7'h02, 8'h88);
        wr_reg(7'h02, 8'h89);
        wr_reg(7'h01, 8'hc0);
        repeat (60) @(posedge core_clk);
        chk("pin pulse", 16'(low_cycles - l0), 16'h0028);
        rd_chk("soft keep two", 7'h02, 8'h88);
        $display("end soft reset test");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        resetn = 1'b0;
        {wstb, rstb, restart, otemp, ovolt} = 5'h00;
        addr = 2'h0;
        wdata = 16'h0000;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_rw();
        t_modes();
        t_restart();
        t_heat();
        t_ovolt();
        t_reserved();
        t_soft();
        tally_and_finish();
    end
endmodule
`default_nettype wire
